// file: design/vic_defs.svh
// Purpose: constants of the vectored interrupt controller
// Assumes: byte-wide registers on 32-bit classic Wishbone words
// Notes: offsets are byte addresses
`ifndef VIC_DEFS_SVH
`define VIC_DEFS_SVH
// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define VIC_OFS_CORE 6'h00
`define VIC_OFS_EDGE 6'h04
`define VIC_OFS_CTLA 6'h08
`define VIC_OFS_CTLB 6'h0C
`define VIC_OFS_TMR 6'h10
`define VIC_OFS_MISC 6'h14
`define VIC_OFS_STACK 6'h18
// ----------------------------------------------------------------
// field masks and reset values
// ----------------------------------------------------------------
`define VIC_MASK_CORE 8'h37
`define VIC_MASK_EDGE 8'h0F
`define VIC_MASK_CTLA 8'hFF
`define VIC_MASK_CTLB 8'h22
`define VIC_MASK_TMR 8'hFF
`define VIC_MASK_MISC 8'h33
`define VIC_RST_REG 8'h00
// ----------------------------------------------------------------
// edge select codes
// ----------------------------------------------------------------
`define VIC_EDGE_OFF 2'b00
`define VIC_EDGE_RISE 2'b01
`define VIC_EDGE_FALL 2'b10
`define VIC_EDGE_BOTH 2'b11
`endif

// file: design/vic_pkg.sv
// Purpose: types of the vectored interrupt controller
// Assumes: nothing beyond the defs header
// Notes: source index order is also the default priority
package vic_pkg;
    parameter int NSRC = 7;
    typedef logic [NSRC-1:0] src_vec_t;
    typedef struct packed {
        logic [5:0] adr;
        logic [31:0] dat;
        logic [3:0] sel;
        logic we;
        logic cyc;
        logic stb;
    } wb_req_s;
    typedef struct packed {
        logic [31:0] dat;
        logic ack;
    } wb_rsp_s;
    typedef struct packed {
        logic tb0;
        logic tb1;
        logic serial;
        logic ptm_a;
        logic ptm_p;
        logic ctm_a;
        logic ctm_p;
        logic eeprom;
        logic lowv;
    } src_evt_s;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_TAKE = 2'b01,
        ST_WAIT = 2'b10
    } vic_state_e;
endpackage

// file: design/vectored_interrupt_controller.sv
// Purpose: vectored interrupt controller with wishbone registers
// Assumes: core samples take_o/vector_o and answers return pulses
// Notes: one design file; registers one byte per word
//
// Added by the designer: the address map and the Wishbone slave port.
`timescale 1ns/100ps
`include "vic_defs.svh"
module vectored_interrupt_controller #(
    parameter int PCW = 12,
    parameter int DEPTH = 8,
    parameter int SPW = 4,
    // index: 0 pin a,1 pin b,2 tb0,3 serial,4 grp0,5 grp1,6 tb1
    parameter logic [20:0] PRIO = 21'o6543210,
    parameter logic [7*PCW-1:0] VECTORS = {12'h01C, 12'h018, 12'h014,
        12'h010, 12'h00C, 12'h008, 12'h004}
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire vic_pkg::wb_req_s wb_i,
    output vic_pkg::wb_rsp_s wb_o,
    input wire vic_pkg::src_evt_s evt_i,
    input wire logic ext_pin_a_i,
    input wire logic ext_pin_b_i,
    input wire logic pull_high_a_i,
    input wire logic pull_high_b_i,
    input wire logic [PCW-1:0] next_pc_i,
    input wire logic return_from_interrupt_i,
    output logic take_o,
    output logic [PCW-1:0] vector_o,
    output logic [PCW-1:0] return_pc_o,
    output logic resume_o,
    output logic wake_o,
    output logic pull_a_o,
    output logic pull_b_o,
    output logic stack_full_o
);
    import vic_pkg::*;

    // ----------------------------------------------------------------
    // functions
    // ----------------------------------------------------------------
    function automatic logic edge_hit(input logic [1:0] mode,
                                      input logic now, input logic was);
        logic r;
        r = 1'b0;
        case (mode)
            `VIC_EDGE_RISE: r = now & ~was;
            `VIC_EDGE_FALL: r = ~now & was;
            `VIC_EDGE_BOTH: r = now ^ was;
            default: r = 1'b0;
        endcase
        return r;
    endfunction

    function automatic logic [7:0] upd(input logic [7:0] cur,
                                       input logic [7:0] wr,
                                       input logic hit,
                                       input logic [7:0] mask);
        return hit ? (wr & mask) : cur;
    endfunction

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    logic [7:0] core_q, edge_q, ctla_q, ctlb_q, tmr_q, misc_q;
    logic [1:0] pa_q, pb_q;
    logic pa_old_q, pb_old_q;
    logic [PCW-1:0] stack_q [DEPTH];
    logic [SPW-1:0] sp_q;
    vic_state_e st_q;
    logic ack_q;
    logic [31:0] rdat_q;
    logic take_q, resume_q, wake_q, pulla_q, pullb_q;
    logic [PCW-1:0] vec_q, rpc_q;
    logic full_q;

    // ----------------------------------------------------------------
    // bus decode
    // ----------------------------------------------------------------
    wire bus_req = wb_i.cyc & wb_i.stb & ~ack_q;
    // write lands on the acknowledged edge, request still held
    wire wr_en = wb_i.cyc & wb_i.stb & ack_q & wb_i.we & wb_i.sel[0];
    wire [7:0] wd = wb_i.dat[7:0];
    wire hit_core = wr_en & (wb_i.adr == `VIC_OFS_CORE);
    wire hit_edge = wr_en & (wb_i.adr == `VIC_OFS_EDGE);
    wire hit_ctla = wr_en & (wb_i.adr == `VIC_OFS_CTLA);
    wire hit_ctlb = wr_en & (wb_i.adr == `VIC_OFS_CTLB);
    wire hit_tmr = wr_en & (wb_i.adr == `VIC_OFS_TMR);
    wire hit_misc = wr_en & (wb_i.adr == `VIC_OFS_MISC);
    wire [7:0] sp_byte = 8'(sp_q);
    wire [7:0] rd_mux =
        (wb_i.adr == `VIC_OFS_CORE) ? core_q :
        (wb_i.adr == `VIC_OFS_EDGE) ? edge_q :
        (wb_i.adr == `VIC_OFS_CTLA) ? ctla_q :
        (wb_i.adr == `VIC_OFS_CTLB) ? ctlb_q :
        (wb_i.adr == `VIC_OFS_TMR) ? tmr_q :
        (wb_i.adr == `VIC_OFS_MISC) ? misc_q :
        (wb_i.adr == `VIC_OFS_STACK) ? sp_byte : 8'h00;

    // ----------------------------------------------------------------
    // pin edges
    // ----------------------------------------------------------------
    wire pa_s = pa_q[1];
    wire pb_s = pb_q[1];
    wire pa_evt = edge_hit(edge_q[1:0], pa_s, pa_old_q);
    wire pb_evt = edge_hit(edge_q[3:2], pb_s, pb_old_q);

    // ----------------------------------------------------------------
    // arbitration
    // ----------------------------------------------------------------
    // core reg: 0 global, 1 pin a en, 2 pin b en, 4 pin a, 5 pin b req
    wire [7:0] tmr_set = {evt_i.ptm_a, evt_i.ptm_p, evt_i.ctm_a,
                          evt_i.ctm_p, 4'h0};
    wire [7:0] misc_set = {2'b00, evt_i.eeprom, evt_i.lowv, 4'h0};
    wire [7:0] tmr_n = upd(tmr_q, wd, hit_tmr, `VIC_MASK_TMR) | tmr_set;
    wire [7:0] misc_n = upd(misc_q, wd, hit_misc, `VIC_MASK_MISC) | misc_set;
    // group flag follows each set event of an enabled contained flag, even one already set
    wire grp0_evt = |(tmr_set[7:4] & tmr_q[3:0]);
    wire grp1_evt = |(misc_set[5:4] & misc_q[1:0]);
    src_vec_t pend;
    assign pend = {ctlb_q[5] & ctlb_q[1], ctla_q[5] & ctla_q[1],
                   ctla_q[4] & ctla_q[0], ctla_q[6] & ctla_q[2],
                   ctla_q[7] & ctla_q[3], core_q[5] & core_q[2],
                   core_q[4] & core_q[1]};
    wire full = (sp_q == SPW'(DEPTH));
    wire can_take = core_q[0] & ~full & (st_q == ST_IDLE);
    logic [2:0] win;
    logic any;
    always_comb begin
        win = 3'd0;
        any = 1'b0;
        for (int k = NSRC - 1; k >= 0; k--) begin
            if (pend[PRIO[3*k +: 3]]) begin
                win = PRIO[3*k +: 3];
                any = 1'b1;
            end
        end
    end
    wire accept = can_take & any;
    wire [7:0] clr_core = (accept && win == 3'd0) ? 8'h11 :
                          (accept && win == 3'd1) ? 8'h21 :
                          accept ? 8'h01 : 8'h00;
    wire [7:0] clr_ctla = !accept ? 8'h00 :
                          (win == 3'd2) ? 8'h80 : (win == 3'd3) ? 8'h40 :
                          (win == 3'd4) ? 8'h10 :
                          (win == 3'd5) ? 8'h20 : 8'h00;
    wire [7:0] clr_ctlb = (accept && win == 3'd6) ? 8'h20 : 8'h00;
    // set wins over clear and over a write of zero
    wire [7:0] set_core = {2'b00, pb_evt, pa_evt, 4'h0};
    wire [7:0] set_ctla = {evt_i.tb0, evt_i.serial, grp1_evt, grp0_evt,
                           4'h0};
    wire [7:0] set_ctlb = {2'b00, evt_i.tb1, 5'h00};
    wire [7:0] core_n = (upd(core_q, wd, hit_core, `VIC_MASK_CORE)
                         & ~clr_core) | set_core;
    wire [7:0] ctla_n = (upd(ctla_q, wd, hit_ctla, `VIC_MASK_CTLA)
                         & ~clr_ctla) | set_ctla;
    wire [7:0] ctlb_n = (upd(ctlb_q, wd, hit_ctlb, `VIC_MASK_CTLB)
                         & ~clr_ctlb) | set_ctlb;
    wire flag_rise = |(set_core & ~core_q) | |(set_ctla & ~ctla_q) |
                     |(set_ctlb & ~ctlb_q) | |(tmr_set & ~tmr_q) |
                     |(misc_set & ~misc_q);
    wire do_pop = return_from_interrupt_i & (sp_q != '0);

    // ----------------------------------------------------------------
    // return path and stack pointer
    // ----------------------------------------------------------------
    // a pop that meets an accept would lose its pointer update, so it is dropped, as is any pop outside idle
    wire idle = (st_q == ST_IDLE);
    wire pop_ok = do_pop & ~accept & idle;
    // pointer next value is shared by the pointer register and the full flag
    wire [SPW-1:0] sp_inc = sp_q + SPW'(1);
    wire [SPW-1:0] sp_dec = sp_q - SPW'(1);
    wire [SPW-1:0] sp_d = accept ? sp_inc : pop_ok ? sp_dec : sp_q;
    wire [PCW-1:0] win_vec = VECTORS[PCW*win +: PCW];
    wire [PCW-1:0] top_pc = stack_q[sp_dec[SPW-2:0]];

    // ----------------------------------------------------------------
    // register file
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            core_q <= `VIC_RST_REG;
            edge_q <= `VIC_RST_REG;
        end else begin
            core_q <= core_n;
            edge_q <= upd(edge_q, wd, hit_edge, `VIC_MASK_EDGE);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctla_q <= `VIC_RST_REG;
            ctlb_q <= `VIC_RST_REG;
        end else begin
            ctla_q <= ctla_n;
            ctlb_q <= ctlb_n;
        end
    end

    // source flags are never cleared by service, only by software
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tmr_q <= `VIC_RST_REG;
            misc_q <= `VIC_RST_REG;
        end else begin
            tmr_q <= tmr_n;
            misc_q <= misc_n;
        end
    end

    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pa_q <= 2'b00;
            pb_q <= 2'b00;
        end else begin
            pa_q <= {pa_q[0], ext_pin_a_i};
            pb_q <= {pb_q[0], ext_pin_b_i};
        end
    end

    // edge select resets off, so the reset fill of the history is harmless
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pa_old_q <= 1'b0;
            pb_old_q <= 1'b0;
        end else begin
            pa_old_q <= pa_s;
            pb_old_q <= pb_s;
        end
    end

    // ----------------------------------------------------------------
    // accept sequencer
    // ----------------------------------------------------------------
    // one accept per return handshake window keeps a single push
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_q <= ST_IDLE;
        end else begin
            case (st_q)
                ST_IDLE: begin
                    if (accept) begin
                        st_q <= ST_TAKE;
                    end
                end
                ST_TAKE: st_q <= ST_WAIT;
                ST_WAIT: st_q <= ST_IDLE;
                default: st_q <= ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sp_q <= '0;
            full_q <= 1'b0;
        end else begin
            sp_q <= sp_d;
            full_q <= (sp_d == SPW'(DEPTH));
        end
    end

    // no reset: only entries below the pointer are ever read
    always_ff @(posedge clk_i) begin
        if (accept) begin
            stack_q[sp_q[SPW-2:0]] <= next_pc_i;
        end
    end

    // ----------------------------------------------------------------
    // core handshake outputs
    // ----------------------------------------------------------------
    // vector holds after the pulse for a late reader
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            take_q <= 1'b0;
            vec_q <= '0;
        end else begin
            take_q <= accept;
            if (accept) begin
                vec_q <= win_vec;
            end
        end
    end

    // the saved pc is only meaningful with its resume pulse
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            resume_q <= 1'b0;
            rpc_q <= '0;
        end else begin
            resume_q <= pop_ok;
            if (pop_ok) begin
                rpc_q <= top_pc;
            end
        end
    end

    // one pulse per cycle in which any hardware flag rises, software writes never wake
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wake_q <= 1'b0;
        end else begin
            wake_q <= flag_rise;
        end
    end

    // pull selection bypasses the edge logic, so it stays in force
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pulla_q <= 1'b0;
            pullb_q <= 1'b0;
        end else begin
            pulla_q <= pull_high_a_i;
            pullb_q <= pull_high_b_i;
        end
    end

    // ----------------------------------------------------------------
    // bus response
    // ----------------------------------------------------------------
    // ack lasts one cycle, so a request held over it is taken once
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
            rdat_q <= 32'h0000_0000;
        end else begin
            ack_q <= bus_req;
            rdat_q <= {24'h00_0000, rd_mux};
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign take_o = take_q;
    assign vector_o = vec_q;
    assign return_pc_o = rpc_q;
    assign resume_o = resume_q;
    assign wake_o = wake_q;
    assign pull_a_o = pulla_q;
    assign pull_b_o = pullb_q;
    assign stack_full_o = full_q;
    assign wb_o.ack = ack_q;
    assign wb_o.dat = rdat_q;
endmodule // vectored_interrupt_controller

// file: sim/vic_asserts.sv
// Purpose: port checks of the interrupt controller
// Assumes: classic wishbone master, one clock
// Notes: bound to every controller instance
`timescale 1ns/100ps
`include "vic_defs.svh"
module vic_asserts #(
    parameter int PCW = 12
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire vic_pkg::wb_req_s wb_i,
    input wire vic_pkg::wb_rsp_s wb_o,
    input wire logic pull_high_a_i,
    input wire logic pull_high_b_i,
    input wire logic return_from_interrupt_i,
    input wire logic take_o,
    input wire logic [PCW-1:0] vector_o,
    input wire logic resume_o,
    input wire logic pull_a_o,
    input wire logic pull_b_o,
    input wire logic stack_full_o
);
    import vic_pkg::*;
    // ----
    // read bits that must stay zero
    // ----
    wire logic [7:0] rsv_w =
        wb_i.adr == `VIC_OFS_CORE ? ~`VIC_MASK_CORE :
        wb_i.adr == `VIC_OFS_EDGE ? ~`VIC_MASK_EDGE :
        wb_i.adr == `VIC_OFS_CTLB ? ~`VIC_MASK_CTLB :
        wb_i.adr == `VIC_OFS_MISC ? ~`VIC_MASK_MISC :
        wb_i.adr == `VIC_OFS_STACK ? 8'hF0 :
        wb_i.adr < 6'h18 ? 8'h00 : 8'hFF;
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    a_ack_follows: assert property (
        wb_i.cyc && wb_i.stb && !wb_o.ack |=> wb_o.ack)
        else $error("bus request not acked");
    a_ack_single: assert property (wb_o.ack |=> !wb_o.ack)
        else $error("ack longer than one cycle");
    a_rsvd_zero: assert property (
        wb_o.ack && !wb_i.we |-> (wb_o.dat & {24'hFFFFFF, rsv_w}) == 0)
        else $error("reserved read bit set");
    a_take_spaced: assert property (take_o |=> !take_o [*2])
        else $error("accepts too close");
    a_full_blocks: assert property (stack_full_o |=> !take_o)
        else $error("accept with full stack");
    a_full_holds: assert property (
        stack_full_o && !return_from_interrupt_i |=> stack_full_o)
        else $error("full stack left without pop");
    a_resume_cause: assert property (
        resume_o |-> $past(return_from_interrupt_i))
        else $error("resume without return");
    a_vector_hold: assert property (!take_o |-> $stable(vector_o))
        else $error("vector moved without accept");
    a_pull_copy: assert property (!$past(rst_i) |->
        pull_a_o == $past(pull_high_a_i) && pull_b_o == $past(pull_high_b_i))
        else $error("pull-high not kept");
endmodule // vic_asserts
bind vectored_interrupt_controller vic_asserts #(.PCW(PCW)) u_vic_asserts (
    .clk_i(clk_i), .rst_i(rst_i), .wb_i(wb_i), .wb_o(wb_o),
    .pull_high_a_i(pull_high_a_i), .pull_high_b_i(pull_high_b_i),
    .return_from_interrupt_i(return_from_interrupt_i),
    .take_o(take_o), .vector_o(vector_o), .resume_o(resume_o),
    .pull_a_o(pull_a_o), .pull_b_o(pull_b_o), .stack_full_o(stack_full_o)
);

// file: sim/core_model.sv
// Purpose: processor core beside the controller
// Assumes: one return per accepted interrupt
// Notes: return delay follows pc bits, 3 to 10 cycles
`timescale 1ns/100ps
module core_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic take_i,
    input wire logic ret_en_i,
    output logic [11:0] next_pc_o,
    output logic ret_o
);
    int pend_q;
    logic [3:0] dly_q;
    // ----
    // pc walk and return pulses
    // ----
    // delay keeps a return out of the busy cycles after an accept
    always_ff @(posedge clk_i) begin
        next_pc_o <= rst_i ? 12'h000 : next_pc_o + 12'h003;
        ret_o <= 1'b0;
        if (rst_i) begin
            pend_q <= 0;
            dly_q <= 4'h0;
        end else if (take_i) begin
            pend_q <= pend_q + 1;
            dly_q <= 4'h3 + {1'b0, next_pc_o[2:0]};
        end else if (dly_q != 4'h0) begin
            dly_q <= dly_q - 4'h1;
        end else if (pend_q > 0 && ret_en_i) begin
            ret_o <= 1'b1;
            pend_q <= pend_q - 1;
            dly_q <= 4'h4;
        end
    end
endmodule // core_model

// file: sim/vectored_interrupt_controller_tb_top.sv
// Purpose: self-checking bench of the interrupt controller
// Assumes: default design parameters
// Notes: drivers queue results, a monitor compares them
`timescale 1ns/100ps
`include "vic_defs.svh"
module vectored_interrupt_controller_tb_top;
    import vic_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    wb_req_s wb_q = '0;
    wb_rsp_s rsp;
    src_evt_s evt_q = '0;
    logic pin_a_q = 1'b0;
    logic pin_b_q = 1'b0;
    logic ph_a_q = 1'b0;
    logic ph_b_q = 1'b0;
    logic ret_en_q = 1'b1;
    logic [11:0] pc, vec, rpc, prev_pc;
    logic ret, take, resume, wake, full, pa, pb;
    logic [31:0] q_rd[$];
    logic [11:0] q_vec[$], q_pc[$];
    int err_count = 0, n_checks = 0, wakes = 0, seed = 3528;
    logic [5:0] ofs[8] = '{6'h00, 6'h04, 6'h08, 6'h0C, 6'h10, 6'h14,
        6'h18, 6'h1C};
    logic [7:0] msk[8] = '{`VIC_MASK_CORE, `VIC_MASK_EDGE, `VIC_MASK_CTLA,
        `VIC_MASK_CTLB, `VIC_MASK_TMR, `VIC_MASK_MISC, 8'h00, 8'h00};
    vectored_interrupt_controller u_vectored_interrupt_controller (
        .clk_i(clk_i), .rst_i(rst_i), .wb_i(wb_q), .wb_o(rsp),
        .evt_i(evt_q), .ext_pin_a_i(pin_a_q), .ext_pin_b_i(pin_b_q),
        .pull_high_a_i(ph_a_q), .pull_high_b_i(ph_b_q), .next_pc_i(pc),
        .return_from_interrupt_i(ret), .take_o(take), .vector_o(vec),
        .return_pc_o(rpc), .resume_o(resume), .wake_o(wake),
        .pull_a_o(pa), .pull_b_o(pb), .stack_full_o(full));
    core_model u_core_model (.clk_i(clk_i), .rst_i(rst_i), .take_i(take),
        .ret_en_i(ret_en_q), .next_pc_o(pc), .ret_o(ret));
    initial begin
        forever #5 clk_i = ~clk_i;
    end
    always @(posedge clk_i) {ph_a_q, ph_b_q} <= 2'($random(seed));
    // ----
    // checks and bus cycles
    // ----
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic tally_and_finish;
        $display("checks %0d errors %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic bus(input logic [5:0] a, input logic [7:0] d,
        input logic w);
        // only the watchdog ends a wait for ack
        wb_q <= '{a, {24'h0, d}, 4'h1, w, 1'b1, 1'b1};
        do @(posedge clk_i); while (!rsp.ack);
        wb_q.cyc <= 1'b0;
        wb_q.stb <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic rd(input logic [5:0] a, input logic [7:0] e);
        q_rd.push_back({24'h0, e});
        bus(a, 8'h00, 1'b0);
    endtask
    task automatic fire(input src_evt_s e);
        evt_q <= e;
        @(posedge clk_i);
        evt_q <= '0;
        repeat (20) @(posedge clk_i);
    endtask
    always @(posedge clk_i) begin
        prev_pc <= pc;
        if (wake) wakes++;
        if (rsp.ack && !wb_q.we) chk(rsp.dat, q_rd.pop_front());
        if (resume) chk(32'(rpc),
            q_pc.size() ? 32'(q_pc.pop_back()) : 32'hFFFFFFFF);
        if (take) chk(32'(vec),
            q_vec.size() ? 32'(q_vec.pop_front()) : 32'hFFFFFFFF);
        if (take) q_pc.push_back(prev_pc);
    end
    initial begin
        #200000;
        err_count++;
        tally_and_finish;
    end
    initial begin
        logic [7:0] v;
        logic hit;
        int w0;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        foreach (ofs[i]) rd(ofs[i], 8'h00);
        foreach (ofs[i]) begin
            v = 8'($random(seed)) & (i == 0 ? 8'hFE : 8'hFF);
            bus(ofs[i], v, 1'b1);
            rd(ofs[i], v & msk[i]);
            bus(ofs[i], 8'h00, 1'b1);
        end
        for (int c = 0; c < 4; c++) begin
            bus(`VIC_OFS_EDGE, 8'(c), 1'b1);
            for (int k = 0; k < 2; k++) begin
                hit = c == k + 1 || c == 3;
                bus(`VIC_OFS_CORE, 8'h03, 1'b1);
                if (hit) q_vec.push_back(12'h004);
                pin_a_q <= !pin_a_q;
                repeat (20) @(posedge clk_i);
                rd(`VIC_OFS_CORE, hit ? 8'h02 : 8'h03);
            end
        end
        bus(`VIC_OFS_EDGE, 8'h0C, 1'b1);
        bus(`VIC_OFS_CORE, 8'h05, 1'b1);
        q_vec.push_back(12'h008);
        pin_b_q <= 1'b1;
        repeat (20) @(posedge clk_i);
        rd(`VIC_OFS_CORE, 8'h04);
        w0 = wakes;
        fire('{ptm_a: 1'b1, default: 1'b0});
        chk(32'(wakes - w0), 32'h1);
        rd(`VIC_OFS_TMR, 8'h80);
        bus(`VIC_OFS_TMR, 8'h88, 1'b1);
        bus(`VIC_OFS_CTLA, 8'h09, 1'b1);
        bus(`VIC_OFS_CORE, 8'h01, 1'b1);
        q_vec.push_back(12'h014);
        fire('{ptm_a: 1'b1, default: 1'b0});
        rd(`VIC_OFS_TMR, 8'h88);
        fire('{tb0: 1'b1, default: 1'b0});
        rd(`VIC_OFS_CTLA, 8'h89);
        q_vec.push_back(12'h00C);
        bus(`VIC_OFS_CORE, 8'h01, 1'b1);
        repeat (20) @(posedge clk_i);
        rd(`VIC_OFS_CTLA, 8'h09);
        bus(`VIC_OFS_CTLA, 8'h0C, 1'b1);
        bus(`VIC_OFS_CTLB, 8'h02, 1'b1);
        fire('{tb0: 1'b1, serial: 1'b1, tb1: 1'b1, default: 1'b0});
        foreach (ofs[i]) if (i < 3) begin
            q_vec.push_back(i == 0 ? 12'h00C : i == 1 ? 12'h010 : 12'h01C);
            bus(`VIC_OFS_CORE, 8'h01, 1'b1);
            repeat (20) @(posedge clk_i);
        end
        bus(`VIC_OFS_MISC, 8'h01, 1'b1);
        bus(`VIC_OFS_CTLA, 8'h02, 1'b1);
        fire('{eeprom: 1'b1, lowv: 1'b1, ctm_p: 1'b1, default: 1'b0});
        rd(`VIC_OFS_MISC, 8'h31);
        rd(`VIC_OFS_CTLA, 8'h22);
        q_vec.push_back(12'h018);
        bus(`VIC_OFS_CORE, 8'h01, 1'b1);
        repeat (20) @(posedge clk_i);
        rd(`VIC_OFS_CTLA, 8'h02);
        bus(`VIC_OFS_CTLA, 8'h0C, 1'b1);
        ret_en_q <= 1'b0;
        for (int i = 0; i < 9; i++) begin
            if (i < 8) q_vec.push_back(12'h00C);
            bus(`VIC_OFS_CORE, 8'h01, 1'b1);
            fire('{tb0: 1'b1, default: 1'b0});
        end
        chk(32'(full), 32'h1);
        rd(`VIC_OFS_STACK, 8'h08);
        q_vec.push_back(12'h00C);
        ret_en_q <= 1'b1;
        repeat (200) @(posedge clk_i);
        rd(`VIC_OFS_STACK, 8'h00);
        tally_and_finish;
    end
endmodule // vectored_interrupt_controller_tb_top
